// ==== rtl/linear_regulator_voltage_regs.sv ====
// Purpose: Register bank and voltage decode of the linear regulators.
// Assumes: Byte register port driven by the serial control engine on i_core_clk.
// Notes:   Regulator index 10 in scan and flag vectors is the keep-alive regulator.
//
// Overview of operation
// - Four dynamic regulator 2 set registers, 5-bit code in bits 4..0.
// - Regulator 2 code decodes from 0.725 V in 25 mV steps to 1.500 V.
// - Dynamic regulator targets ramp at about 7 mV per microsecond.
// - Two dynamic regulator 4 set registers, 5-bit code in bits 4..0.
// - Regulator 4 code decodes from 1.700 V in 25 mV steps to 2.475 V.
// - Output below 95 percent of programmed level flags not power-good.
// - Discharge switch closes when a regulator other than keep-alive is off.
// - Discharge stays enabled in normal state and supply sequencing state.
// - Keep-alive regulator runs only while bit 7 of register four is set.
// - Bit 6 of register four picks keep-alive good level 2.4 V or 2.0 V.
// - Register one holds regulator 0 code bits 7..5, regulator 1 bits 4..0.
// - Register three holds regulator 7 and 6 codes, bits 7..6 spare storage.
// - Register four holds keep-alive code bits 5..3, regulator 3 bits 2..0.
// - Register six holds regulator 9 and 5 codes, bits 7..6 unused.
// - 3-bit codes decode to 1.25, 1.50, 1.80, 2.50, 2.70, 2.85, 3.10, 3.30 V.
// - Regulator 0 decodes the same, except code 000 gives 1.20 V.
// - Regulator 1 code decodes from 0.725 V in 25 mV steps.
// - Keep-alive level below good level pulses lost flag on reboot or wake.
// - Keep-alive level below lockout level disables the real-time counter.
// - Register two holds regulator 8 code bits 7..5 beside a buck field.
`timescale 1ns/10ps
`include "lin_reg_consts.svh"

module linear_regulator_voltage_regs
  import lin_reg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  // Sequencer side
  input  wire logic [1:0]  i_dyn2_sel,
  input  wire logic        i_dyn4_sel,
  input  wire logic [9:0]  i_reg_en,
  input  wire logic        i_state_normal,
  input  wire logic        i_supply_sequencing_state,
  input  wire logic        i_reboot_or_wake,
  // Output level scan
  input  wire logic        i_meas_vld,
  input  wire logic [3:0]  i_meas_idx,
  input  wire logic [11:0] i_meas_mv,
  // Targets in millivolts and the buck two code
  output mv_t              o_lin_reg_0_mv,
  output mv_t              o_lin_reg_1_mv,
  output mv_t              o_lin_reg_2_mv,
  output mv_t              o_lin_reg_3_mv,
  output mv_t              o_lin_reg_4_mv,
  output mv_t              o_lin_reg_5_mv,
  output mv_t              o_lin_reg_6_mv,
  output mv_t              o_lin_reg_7_mv,
  output mv_t              o_lin_reg_8_mv,
  output mv_t              o_lin_reg_9_mv,
  output mv_t              o_keepalive_mv,
  output logic [4:0]       o_buck_two_code,
  // Switch and status outputs
  output logic [9:0]       o_discharge,
  output logic             o_keepalive_reg_on,
  output mv_t              o_keepalive_good_level,
  output logic             o_keepalive_lost_pulse,
  output logic             o_rtc_disable,
  output logic [10:0]      o_not_good
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic mv_t dec5(input logic [4:0] code, input mv_t base);
    dec5 = 12'(base + 12'(code) * `MV_STEP_25);
  endfunction

  function automatic mv_t dec3(input logic [2:0] code, input logic is_reg0);
    case (code)
      3'h0:    dec3 = is_reg0 ? `MV_REG0_LOWEST : 12'h4E2;
      3'h1:    dec3 = 12'h5DC;
      3'h2:    dec3 = 12'h708;
      3'h3:    dec3 = 12'h9C4;
      3'h4:    dec3 = 12'hA8C;
      3'h5:    dec3 = 12'hB22;
      3'h6:    dec3 = 12'hC1C;
      default: dec3 = 12'hCE4;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [4:0] dyn2_r [0:3];
  logic [4:0] dyn4_r [0:1];
  logic [7:0] fv1_r;
  logic [7:0] fv2_r;
  logic [7:0] fv3_r;
  logic [7:0] fv4_r;
  logic [5:0] fv6_r;
  logic [7:0] rdata_nxt;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < 4; k++) begin
        dyn2_r[k] <= 5'h00;
      end
      dyn4_r[0] <= 5'h00;
      dyn4_r[1] <= 5'h00;
      fv1_r     <= `RST_REG_BYTE;
      fv2_r     <= `RST_REG_BYTE;
      fv3_r     <= `RST_REG_BYTE;
      fv4_r     <= `RST_REG_BYTE;
      fv6_r     <= 6'h00;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `OFS_DYN2_SET_A_FIRST:     dyn2_r[0] <= i_reg_wdata[4:0];
        `OFS_DYN2_SET_A_SECOND:    dyn2_r[1] <= i_reg_wdata[4:0];
        `OFS_DYN2_SET_B_FIRST:     dyn2_r[2] <= i_reg_wdata[4:0];
        `OFS_DYN2_SET_B_SECOND:    dyn2_r[3] <= i_reg_wdata[4:0];
        `OFS_DYN4_SET_FIRST:       dyn4_r[0] <= i_reg_wdata[4:0];
        `OFS_DYN4_SET_SECOND:      dyn4_r[1] <= i_reg_wdata[4:0];
        `OFS_FIXED_VOLT_SEL_ONE:   fv1_r     <= i_reg_wdata;
        `OFS_FIXED_VOLT_SEL_TWO:   fv2_r     <= i_reg_wdata;
        `OFS_FIXED_VOLT_SEL_THREE: fv3_r     <= i_reg_wdata;
        `OFS_FIXED_VOLT_SEL_FOUR:  fv4_r     <= i_reg_wdata;
        `OFS_FIXED_VOLT_SEL_SIX:   fv6_r     <= i_reg_wdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_comb begin
    case (i_reg_addr)
      `OFS_DYN2_SET_A_FIRST:     rdata_nxt = {3'h0, dyn2_r[0]};
      `OFS_DYN2_SET_A_SECOND:    rdata_nxt = {3'h0, dyn2_r[1]};
      `OFS_DYN2_SET_B_FIRST:     rdata_nxt = {3'h0, dyn2_r[2]};
      `OFS_DYN2_SET_B_SECOND:    rdata_nxt = {3'h0, dyn2_r[3]};
      `OFS_DYN4_SET_FIRST:       rdata_nxt = {3'h0, dyn4_r[0]};
      `OFS_DYN4_SET_SECOND:      rdata_nxt = {3'h0, dyn4_r[1]};
      `OFS_FIXED_VOLT_SEL_ONE:   rdata_nxt = fv1_r;
      `OFS_FIXED_VOLT_SEL_TWO:   rdata_nxt = fv2_r;
      `OFS_FIXED_VOLT_SEL_THREE: rdata_nxt = fv3_r;
      `OFS_FIXED_VOLT_SEL_FOUR:  rdata_nxt = fv4_r;
      `OFS_FIXED_VOLT_SEL_SIX:   rdata_nxt = {2'h0, fv6_r};
      default:                   rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fixed regulator decode
  // ----------------------------------------------------------------
  mv_t ka_mv;
  mv_t ka_good;

  assign ka_mv   = dec3(fv4_r[5:3], 1'b0);
  assign ka_good = fv4_r[`BIT_KEEPALIVE_GOOD_LEVEL] ? `MV_KA_GOOD_HIGH : `MV_KA_GOOD_LOW;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lin_reg_0_mv  <= `MV_REG0_LOWEST;
      o_lin_reg_1_mv  <= `MV_DYN2_BASE;
      o_lin_reg_3_mv  <= 12'h4E2;
      o_lin_reg_5_mv  <= 12'h4E2;
      o_lin_reg_6_mv  <= 12'h4E2;
      o_lin_reg_7_mv  <= 12'h4E2;
      o_lin_reg_8_mv  <= 12'h4E2;
      o_lin_reg_9_mv  <= 12'h4E2;
      o_keepalive_mv  <= 12'h4E2;
      o_buck_two_code <= 5'h00;
    end else begin
      o_lin_reg_0_mv  <= dec3(fv1_r[7:5], 1'b1);
      o_lin_reg_1_mv  <= dec5(fv1_r[4:0], `MV_DYN2_BASE);
      o_lin_reg_3_mv  <= dec3(fv4_r[2:0], 1'b0);
      o_lin_reg_5_mv  <= dec3(fv6_r[2:0], 1'b0);
      o_lin_reg_6_mv  <= dec3(fv3_r[2:0], 1'b0);
      o_lin_reg_7_mv  <= dec3(fv3_r[5:3], 1'b0);
      o_lin_reg_8_mv  <= dec3(fv2_r[7:5], 1'b0);
      o_lin_reg_9_mv  <= dec3(fv6_r[5:3], 1'b0);
      o_keepalive_mv  <= ka_mv;
      o_buck_two_code <= fv2_r[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Dynamic regulators: selection and ramp
  // ----------------------------------------------------------------
  mv_t      tgt     [0:1];
  mv_t      cur_r   [0:1];
  logic [7:0] cnt_r [0:1];
  ramp_st_t st_r    [0:1];

  assign tgt[0] = dec5(dyn2_r[i_dyn2_sel], `MV_DYN2_BASE);
  assign tgt[1] = dec5(dyn4_r[i_dyn4_sel], `MV_DYN4_BASE);

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_r[0] <= `MV_DYN2_BASE;
      cur_r[1] <= `MV_DYN4_BASE;
      for (int k = 0; k < 2; k++) begin
        cnt_r[k] <= 8'h00;
        st_r[k]  <= RAMP_IDLE;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        case (st_r[k])
          RAMP_IDLE: begin
            cnt_r[k] <= 8'h00;
            if (tgt[k] > cur_r[k]) begin
              st_r[k] <= RAMP_UP;
            end else if (tgt[k] < cur_r[k]) begin
              st_r[k] <= RAMP_DOWN;
            end
          end
          RAMP_UP, RAMP_DOWN: begin
            if (cnt_r[k] == 8'(`RAMP_CYC - 1)) begin
              cnt_r[k] <= 8'h00;
              if (tgt[k] == cur_r[k]) begin
                st_r[k] <= RAMP_IDLE;
              end else if (tgt[k] > cur_r[k]) begin
                cur_r[k] <= cur_r[k] + 12'h001;
                st_r[k]  <= RAMP_UP;
              end else begin
                cur_r[k] <= cur_r[k] - 12'h001;
                st_r[k]  <= RAMP_DOWN;
              end
            end else begin
              cnt_r[k] <= cnt_r[k] + 8'h01;
            end
          end
          default: st_r[k] <= RAMP_IDLE;
        endcase
      end
    end
  end

  assign o_lin_reg_2_mv = cur_r[0];
  assign o_lin_reg_4_mv = cur_r[1];

  // ----------------------------------------------------------------
  // Discharge switches and keep-alive control
  // ----------------------------------------------------------------
  logic dis_allow;

  assign dis_allow = i_state_normal | i_supply_sequencing_state;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_discharge            <= 10'h000;
      o_keepalive_reg_on     <= 1'b0;
      o_keepalive_good_level <= `MV_KA_GOOD_LOW;
      o_keepalive_lost_pulse <= 1'b0;
      o_rtc_disable          <= 1'b0;
    end else begin
      o_discharge            <= ~i_reg_en & {10{dis_allow}};
      o_keepalive_reg_on     <= fv4_r[`BIT_KEEPALIVE_REG_ON];
      o_keepalive_good_level <= ka_good;
      o_keepalive_lost_pulse <= i_reboot_or_wake & (ka_mv < ka_good);
      o_rtc_disable          <= ka_mv < `MV_KA_LOCKOUT;
    end
  end

  // ----------------------------------------------------------------
  // Power-good flags from the output scan
  // ----------------------------------------------------------------
  mv_t prog_mv;

  always_comb begin
    case (i_meas_idx)
      4'h0:    prog_mv = o_lin_reg_0_mv;
      4'h1:    prog_mv = o_lin_reg_1_mv;
      4'h2:    prog_mv = cur_r[0];
      4'h3:    prog_mv = o_lin_reg_3_mv;
      4'h4:    prog_mv = cur_r[1];
      4'h5:    prog_mv = o_lin_reg_5_mv;
      4'h6:    prog_mv = o_lin_reg_6_mv;
      4'h7:    prog_mv = o_lin_reg_7_mv;
      4'h8:    prog_mv = o_lin_reg_8_mv;
      4'h9:    prog_mv = o_lin_reg_9_mv;
      default: prog_mv = o_keepalive_mv;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_not_good <= 11'h000;
    end else if (i_meas_vld && i_meas_idx <= 4'hA) begin
      o_not_good[i_meas_idx] <= (19'(i_meas_mv) * 19'(`PG_FULL)) <
                                (19'(prog_mv) * 19'(`PG_PERCENT));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_wake_low;
    i_reboot_or_wake && (ka_mv < ka_good);
  endsequence

  sequence s_lost_once;
    o_keepalive_lost_pulse ##1 (!o_keepalive_lost_pulse || $past(i_reboot_or_wake));
  endsequence

  a_ka_on_follow: assert property (##1 o_keepalive_reg_on == $past(fv4_r[7]))
    else $error("keep-alive enable does not follow bit 7");

  a_ka_good_sel: assert property (##1 o_keepalive_good_level ==
      ($past(fv4_r[6]) ? 12'h960 : 12'h7D0))
    else $error("keep-alive good level wrong");

  a_discharge_off: assert property (dis_allow && !i_reg_en[3] |=> o_discharge[3])
    else $error("discharge switch open while regulator off");

  a_discharge_on_en: assert property (i_reg_en[0] |=> !o_discharge[0])
    else $error("discharge switch closed while regulator on");

  a_lost_pulse: assert property (s_wake_low |=> s_lost_once)
    else $error("keep-alive lost pulse missing");

  a_lost_cause: assert property (o_keepalive_lost_pulse |-> $past(i_reboot_or_wake))
    else $error("keep-alive lost pulse without cause");

  a_rtc_lockout: assert property (ka_mv >= 12'h708 |=> !o_rtc_disable)
    else $error("counter disabled above lockout");

  a_ka_lockout_on: assert property (ka_mv < 12'h708 |=> o_rtc_disable)
    else $error("counter left running below lockout");

  a_ramp_step: assert property (##1 (cur_r[0] - $past(cur_r[0]) <= 12'h001 ||
      $past(cur_r[0]) - cur_r[0] <= 12'h001))
    else $error("ramp jumped more than one step");

  a_ramp_toward: assert property (##1 cur_r[0] > $past(cur_r[0]) |-> $past(tgt[0]) > $past(cur_r[0]))
    else $error("ramp stepped away from its target");

  a_ramp_hold: assert property ($changed(cur_r[1]) |=> $stable(cur_r[1])[*6])
    else $error("ramp faster than its rate");

  a_reg0_lowest: assert property (fv1_r[7:5] == 3'h0 |=> o_lin_reg_0_mv == 12'h4B0)
    else $error("regulator 0 lowest code wrong");

  a_reg1_top: assert property (fv1_r[4:0] == 5'h1F |=> o_lin_reg_1_mv == 12'h5DC)
    else $error("regulator 1 top code wrong");

  a_reg8_top: assert property (fv2_r[7:5] == 3'h7 |=> o_lin_reg_8_mv == 12'hCE4)
    else $error("regulator 8 top code wrong");

  a_rsvd_zero: assert property (i_reg_rd && i_reg_addr == 8'h46 |=> o_reg_rdata[7:6] == 2'h0)
    else $error("unused bits read non-zero");

  a_pg_flag: assert property (i_meas_vld && i_meas_idx == 4'h3 && i_meas_mv == 12'h000
      |=> o_not_good[3])
    else $error("power-good flag not raised");

endmodule

// ==== rtl/lin_reg_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the regulator bank.
// Assumes: 50 MHz register clock; byte-wide register port.
// Notes:   Levels are carried in millivolts on 12 bits.
`ifndef LIN_REG_CONSTS_SVH
`define LIN_REG_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_DYN2_SET_A_FIRST     8'h29
`define OFS_DYN2_SET_A_SECOND    8'h2A
`define OFS_DYN2_SET_B_FIRST     8'h2F
`define OFS_DYN2_SET_B_SECOND    8'h30
`define OFS_DYN4_SET_FIRST       8'h32
`define OFS_DYN4_SET_SECOND      8'h33
`define OFS_FIXED_VOLT_SEL_ONE   8'h41
`define OFS_FIXED_VOLT_SEL_TWO   8'h42
`define OFS_FIXED_VOLT_SEL_THREE 8'h43
`define OFS_FIXED_VOLT_SEL_FOUR  8'h44
`define OFS_FIXED_VOLT_SEL_SIX   8'h46

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BIT_KEEPALIVE_REG_ON      7
`define BIT_KEEPALIVE_GOOD_LEVEL  6
`define RST_REG_BYTE              8'h00

// ----------------------------------------------------------------
// Levels in millivolts and power-good percentages
// ----------------------------------------------------------------
`define MV_DYN2_BASE     12'h2D5
`define MV_DYN4_BASE     12'h6A4
`define MV_STEP_25       12'h019
`define MV_REG0_LOWEST   12'h4B0
`define MV_KA_GOOD_HIGH  12'h960
`define MV_KA_GOOD_LOW   12'h7D0
`define MV_KA_LOCKOUT    12'h708
`define PG_PERCENT       7'h5F
`define PG_FULL          7'h64

// ----------------------------------------------------------------
// Ramp timing: 7 mV per microsecond, one millivolt per step
// ----------------------------------------------------------------
`define CLK_MHZ          50
`define RAMP_NS_PER_MV   143
`define RAMP_CYC         ((`RAMP_NS_PER_MV * `CLK_MHZ) / 1000)

`endif

// ==== rtl/lin_reg_pkg.sv ====
// Purpose: Types shared by the regulator bank.
// Assumes: Nothing beyond the constants header.
// Notes:   Ramp states follow a Gray sequence.
package lin_reg_pkg;

  typedef logic [11:0] mv_t;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP   = 2'b01,
    RAMP_DOWN = 2'b11
  } ramp_st_t;

endpackage

// ==== testbench/lin_reg_host.sv ====
// Purpose: Host side of the register port, one byte per strobe.
// Assumes: Strobes are one-cycle pulses taken at the rising edge.
// Notes:   Signals change at the falling edge only.
`timescale 1ns/10ps

module lin_reg_host (
  // Clock and read data
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_reg_rdata,
  // Request
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd
);
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr    = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_rd   = 1'b1;
    @(negedge i_core_clk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
    @(negedge i_core_clk);
    d = i_reg_rdata;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench of the regulator register bank.
// Assumes: 50 MHz clock, active-low asynchronous reset.
// Notes:   Expected levels are worked out from the decode tables.
`timescale 1ns/10ps
`include "lin_reg_consts.svh"

module testbench;
  import lin_reg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ck = 1'b0, rstn = 1'b0, sel4 = 1'b0, nrm = 1'b0, seq = 1'b0, wake = 1'b0, vld = 1'b0;
  logic [1:0]  sel2 = 2'h0;
  logic [9:0]  en = 10'h000;
  logic [3:0]  idx = 4'h0;
  logic [11:0] mmv = 12'h000;
  logic [7:0]  ad, wd, rdat;
  logic        wr, rd, ka_on, lost, rtc;
  mv_t         o0, o1, o2, o3, o4, o5, o6, o7, o8, o9, oka, good;
  logic [4:0]  buck;
  logic [9:0]  dis;
  logic [10:0] ng;
  int          fails = 0, n_tests = 0;
  localparam logic [11:0] MV3 [8] = '{12'h4E2, 12'h5DC, 12'h708, 12'h9C4, 12'hA8C, 12'hB22, 12'hC1C, 12'hCE4};

  always #10 ck = ~ck;

  lin_reg_host host_u (.i_core_clk(ck), .i_reg_rdata(rdat), .o_reg_addr(ad), .o_reg_wdata(wd),
    .o_reg_wr(wr), .o_reg_rd(rd));

  linear_regulator_voltage_regs dut_u (.i_core_clk(ck), .i_rstn(rstn), .i_reg_addr(ad), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_dyn2_sel(sel2), .i_dyn4_sel(sel4),
    .i_reg_en(en), .i_state_normal(nrm), .i_supply_sequencing_state(seq), .i_reboot_or_wake(wake),
    .i_meas_vld(vld), .i_meas_idx(idx), .i_meas_mv(mmv), .o_lin_reg_0_mv(o0), .o_lin_reg_1_mv(o1),
    .o_lin_reg_2_mv(o2), .o_lin_reg_3_mv(o3), .o_lin_reg_4_mv(o4), .o_lin_reg_5_mv(o5),
    .o_lin_reg_6_mv(o6), .o_lin_reg_7_mv(o7), .o_lin_reg_8_mv(o8), .o_lin_reg_9_mv(o9),
    .o_keepalive_mv(oka), .o_buck_two_code(buck), .o_discharge(dis), .o_keepalive_reg_on(ka_on),
    .o_keepalive_good_level(good), .o_keepalive_lost_pulse(lost), .o_rtc_disable(rtc), .o_not_good(ng));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    cmp($sformatf("reg %h", a), {4'h0, e}, {4'h0, d});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ck);
  endtask

  task automatic wait_ramp(input bit four, input logic [11:0] e, input int steps);
    int n;
    n = 0;
    while (((four ? o4 : o2) !== e) && n < 7 * steps + 60) begin
      @(negedge ck);
      n++;
    end
    cmp("ramp end", e, four ? o4 : o2);
    cmp("ramp time", 12'h001, 12'((n > 7 * steps - 30) && (n < 7 * steps + 30)));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    settle(2);
    cmp("reg0", `MV_REG0_LOWEST, o0);
    cmp("reg2", `MV_DYN2_BASE, o2);
    cmp("reg4", `MV_DYN4_BASE, o4);
    cmp("good", `MV_KA_GOOD_LOW, good);
    cmp("rtc", 12'h001, 12'(rtc));
    rchk(8'h44, 8'h00);
  endtask

  task automatic t_decode;
    logic [2:0] k, j;
    for (int c = 0; c < 8; c++) begin
      k = 3'(c);
      j = 3'(7 - c);
      host_u.wr(8'h41, {k, 5'(c * 4 + 3)});
      host_u.wr(8'h42, {k, 5'(31 - c)});
      host_u.wr(8'h43, {2'b10, k, j});
      host_u.wr(8'h44, {2'b00, k, j});
      host_u.wr(8'h46, {2'b11, k, j});
      settle(2);
      cmp("reg0", (c == 0) ? `MV_REG0_LOWEST : MV3[c], o0);
      cmp("reg1", `MV_DYN2_BASE + `MV_STEP_25 * 12'(c * 4 + 3), o1);
      cmp("reg8", MV3[c], o8);
      cmp("buck", 12'(31 - c), 12'(buck));
      cmp("reg7", MV3[c], o7);
      cmp("reg6", MV3[7 - c], o6);
      cmp("ka", MV3[c], oka);
      cmp("reg3", MV3[7 - c], o3);
      cmp("reg9", MV3[c], o9);
      cmp("reg5", MV3[7 - c], o5);
      cmp("rtc", 12'(c < 2), 12'(rtc));
      rchk(8'h43, {2'b10, k, j});
      rchk(8'h46, {2'b00, k, j});
      @(negedge ck);
      wake = 1'b1;
      @(negedge ck);
      wake = 1'b0;
      cmp("lost", 12'(c < 3), 12'(lost));
      settle(1);
      cmp("lost end", 12'h000, 12'(lost));
    end
  endtask

  task automatic t_keepalive;
    logic [7:0] v [3] = '{8'hC0, 8'h40, 8'h80};
    for (int i = 0; i < 3; i++) begin
      host_u.wr(8'h44, v[i]);
      settle(2);
      cmp("ka on", 12'(v[i][7]), 12'(ka_on));
      cmp("good", v[i][6] ? `MV_KA_GOOD_HIGH : `MV_KA_GOOD_LOW, good);
      rchk(8'h44, v[i]);
    end
    host_u.wr(8'h50, 8'hAA);
    rchk(8'h50, 8'h00);
    rchk(8'h45, 8'h00);
  endtask

  task automatic t_ramp;
    host_u.wr(8'h29, 8'hFF);
    settle(2);
    cmp("no step", `MV_DYN2_BASE, o2);
    wait_ramp(1'b0, 12'h5DC, 775);
    rchk(8'h29, 8'h1F);
    host_u.wr(8'h2A, 8'hE3);
    rchk(8'h2A, 8'h03);
    rchk(8'h2F, 8'h00);
    @(negedge ck);
    sel2 = 2'h2;
    wait_ramp(1'b0, `MV_DYN2_BASE, 775);
    host_u.wr(8'h30, 8'hA0);
    rchk(8'h30, 8'h00);
    @(negedge ck);
    sel2 = 2'h1;
    wait_ramp(1'b0, 12'h320, 75);
    @(negedge ck);
    sel2 = 2'h3;
    wait_ramp(1'b0, `MV_DYN2_BASE, 75);
    host_u.wr(8'h33, 8'hE2);
    rchk(8'h33, 8'h02);
    @(negedge ck);
    sel4 = 1'b1;
    wait_ramp(1'b1, 12'h6D6, 50);
    host_u.wr(8'h32, 8'h1F);
    rchk(8'h32, 8'h1F);
    @(negedge ck);
    sel4 = 1'b0;
    wait_ramp(1'b1, 12'h9AB, 725);
  endtask

  task automatic t_discharge;
    logic [11:0] p [4] = '{12'h555, 12'hAAA, 12'h0F0, 12'hC00};
    for (int i = 0; i < 4; i++) begin
      @(negedge ck);
      en = p[i][9:0];
      nrm = p[i][10];
      seq = p[i][11];
      settle(2);
      cmp("dis", {2'b00, ~p[i][9:0] & {10{p[i][10] | p[i][11]}}}, {2'b00, dis});
    end
  endtask

  task automatic meas(input logic [3:0] i, input logic [11:0] m, input logic e);
    @(negedge ck);
    vld = 1'b1;
    idx = i;
    mmv = m;
    @(negedge ck);
    vld = 1'b0;
    cmp($sformatf("ng %0d", i), 12'(e), 12'(ng[i]));
  endtask

  task automatic t_good;
    host_u.wr(8'h44, 8'h00);
    settle(2);
    meas(4'h3, 12'h4A3, 1'b1);
    meas(4'h3, 12'h4A4, 1'b0);
    meas(4'hA, 12'h4A3, 1'b1);
    meas(4'h2, 12'h2B0, 1'b1);
    meas(4'h2, 12'h2B1, 1'b0);
    cmp("ng ka", 12'h001, 12'(ng[10]));
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ck);
    @(negedge ck);
    rstn = 1'b1;
    t_reset();
    t_decode();
    t_keepalive();
    t_ramp();
    t_discharge();
    t_good();
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge ck);
    fails++;
    complete_run();
  end
endmodule
